// ==== shared/reader_irq_pkg.sv ====
package reader_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the 8-bit parallel register port
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_INTERRUPT_ENABLE  = 6'h06;
  localparam logic [5:0] OFS_INTERRUPT_REQUEST = 6'h07;
  localparam logic [5:0] OFS_GENERAL_CONTROL   = 6'h09;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INTERRUPT_ENABLE  = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_REQUEST = 8'h00;
  localparam logic [7:0] RST_GENERAL_CONTROL   = 8'h00;
  localparam logic [7:0] RST_READ_DATA         = 8'h00;

  // ----------------------------------------------------------------
  // Interrupt register fields (shared by enable and request)
  // ----------------------------------------------------------------
  localparam int BIT_SET_CLEAR  = 7;
  localparam int BIT_RESERVED   = 6;
  localparam int BIT_TIMER      = 5;
  localparam int BIT_TRANSMIT   = 4;
  localparam int BIT_RECEIVE    = 3;
  localparam int BIT_CMD_DONE   = 2;
  localparam int BIT_NEAR_FULL  = 1;
  localparam int BIT_NEAR_EMPTY = 0;
  localparam int IRQ_SRC_COUNT  = 6;

  // ----------------------------------------------------------------
  // General control fields
  // ----------------------------------------------------------------
  localparam int BIT_STANDBY     = 5;
  localparam int BIT_DEEP_SLEEP  = 4;
  localparam int BIT_CIPHER      = 3;
  localparam int BIT_TIMER_STOP  = 2;
  localparam int BIT_TIMER_START = 1;
  localparam int BIT_QUEUE_FLUSH = 0;

  // ----------------------------------------------------------------
  // Queue geometry and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] QUEUE_DEPTH = 7'h40;
  localparam logic [5:0] CMD_IDLE    = 6'h00;

endpackage : reader_irq_pkg

// ==== verilog/reader_irq_and_control.sv ====
// Function
// - Enable write with bit 7 high sets marked bits, low clears them.
// - Timer and transmit requests reach irq only when enabled.
// - Receive request gated by enable; set on end, else low while receiving.
// - Command-done, near-full, near-empty requests reach irq when enabled.
// - Request write with bit 7 high sets marked flags, low clears.
// - Timer request set when timer counts down to zero.
// - Transmit request set when exchange, auth, nv write or checksum ends.
// - Command-done set on return to idle or unknown command, not host idle.
// - Near-full and near-empty flags latch on alert rise, clear by write.
// - Control bit 5 selects standby, clock keeps running.
// - Control bit 4 selects deep power-down, clock stopped too.
// - Control bit 3 shows cipher; only auth step two sets it.
// - Writing 1 to control bit 2 stops the timer at once.
// - Writing 1 to control bit 1 starts the timer at once.
// - Writing 1 to control bit 0 flushes the queue and overflow flag.
// - Stop, start and flush bits always read back as zero.
// - Main status bit shows any enabled request pending, same as irq.
// - Near-full is 1 when 64 minus byte count is at most threshold.
// - Near-empty is 1 when byte count is at most threshold.
module reader_irq_and_control #(
  parameter logic [5:0] IDLE_CODE = reader_irq_pkg::CMD_IDLE
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Register port, already decoded into one-cycle strobes on mclk
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Event inputs from the engines
  input  wire logic       timer_zero,
  input  wire logic       exchange_tx_done,
  input  wire logic       auth_tx_done,
  input  wire logic       nv_prog_done,
  input  wire logic       checksum_done,
  input  wire logic       receive_done,
  input  wire logic       receive_active,
  input  wire logic [5:0] cmd_code,
  input  wire logic       cmd_host_write,
  input  wire logic       unknown_cmd_start,
  input  wire logic       auth_step_two_ok,
  input  wire logic [6:0] queue_byte_count,
  input  wire logic [5:0] alert_threshold,
  // Outputs to the interrupt pin and the engines
  output logic            irq,
  output logic            main_status_irq,
  output logic            fifo_near_full,
  output logic            fifo_near_empty,
  output logic            standby,
  output logic            deep_sleep,
  output logic            card_cipher_active,
  output logic            timer_stop_strobe,
  output logic            timer_start_strobe,
  output logic            queue_flush_strobe
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Set/clear with mask: bit 7 chooses the direction, low bits the mask
  function automatic logic [5:0] apply_set_clear(
    input logic [5:0] cur,
    input logic [7:0] wd
  );
    logic [5:0] mask;
    mask = wd[5:0];
    if (wd[reader_irq_pkg::BIT_SET_CLEAR]) begin
      apply_set_clear = cur | mask;
    end else begin
      apply_set_clear = cur & ~mask;
    end
  endfunction : apply_set_clear

  // Pack six source bits into a readable byte, bits 7 and 6 read as 0
  function automatic logic [7:0] as_byte(input logic [5:0] v);
    as_byte = {2'b00, v};
  endfunction : as_byte

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [5:0] interrupt_enable;
  logic [5:0] interrupt_request;
  logic [5:0] next_interrupt_enable;
  logic [5:0] next_interrupt_request;
  logic       next_standby;
  logic       next_deep_sleep;
  logic       next_card_cipher_active;
  logic       alert_full_prev;
  logic       alert_empty_prev;
  logic       cmd_was_busy;
  logic [7:0] next_reg_rdata;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic hit_enable;
  wire logic hit_request;
  wire logic hit_control;
  wire logic wr_enable;
  wire logic wr_request;
  wire logic wr_control;

  // Plain compares; other offsets belong to neighbouring blocks
  assign hit_enable  = reg_addr == reader_irq_pkg::OFS_INTERRUPT_ENABLE;
  assign hit_request = reg_addr == reader_irq_pkg::OFS_INTERRUPT_REQUEST;
  assign hit_control = reg_addr == reader_irq_pkg::OFS_GENERAL_CONTROL;
  assign wr_enable   = reg_wr & hit_enable;
  assign wr_request  = reg_wr & hit_request;
  assign wr_control  = reg_wr & hit_control;

  // ----------------------------------------------------------------
  // Queue alert levels
  // ----------------------------------------------------------------
  wire logic [6:0] queue_free;
  wire logic [6:0] threshold_wide;

  // Free space is depth minus count; count never exceeds depth
  assign queue_free     = reader_irq_pkg::QUEUE_DEPTH - queue_byte_count;
  assign threshold_wide = {1'b0, alert_threshold};
  assign fifo_near_full  = queue_free <= threshold_wide;
  assign fifo_near_empty = queue_byte_count <= threshold_wide;

  // ----------------------------------------------------------------
  // Hardware request sources
  // ----------------------------------------------------------------
  wire logic       src_timer;
  wire logic       src_transmit;
  wire logic       src_receive;
  wire logic       src_cmd_done;
  wire logic       src_near_full;
  wire logic       src_near_empty;
  wire logic       cmd_is_idle;
  wire logic [5:0] hw_set;
  wire logic [5:0] hw_clear;

  assign src_timer    = timer_zero;
  // Any of the four finishing engines raises the transmit request
  assign src_transmit = exchange_tx_done | auth_tx_done |
                        nv_prog_done | checksum_done;
  assign src_receive  = receive_done;

  // Return to idle counts only when the engine got there itself;
  // a host write of idle is masked so it never looks like completion
  assign cmd_is_idle  = cmd_code == IDLE_CODE;
  assign src_cmd_done = (cmd_was_busy & cmd_is_idle & ~cmd_host_write)
                        | unknown_cmd_start;

  // Edge, not level: the flag must stay cleared once the host clears
  // it, even though the alert level itself may still be high
  assign src_near_full  = fifo_near_full & ~alert_full_prev;
  assign src_near_empty = fifo_near_empty & ~alert_empty_prev;

  assign hw_set = {src_timer, src_transmit, src_receive,
                   src_cmd_done, src_near_full, src_near_empty};

  // Reception in progress clears the receive flag unless receive_done sets it
  assign hw_clear = {2'b00, receive_active, 3'b000};

  // ----------------------------------------------------------------
  // Next enable and request values
  // ----------------------------------------------------------------
  always_comb begin
    next_interrupt_enable = interrupt_enable;
    if (wr_enable) begin
      // Empty mask leaves the register as it was
      next_interrupt_enable =
        apply_set_clear(interrupt_enable, reg_wdata);
    end
  end

  // Host write first, then hardware clears, then hardware sets, so an
  // event in the cycle of a clearing write is never lost
  always_comb begin
    next_interrupt_request = interrupt_request;
    if (wr_request) begin
      next_interrupt_request =
        apply_set_clear(interrupt_request, reg_wdata);
    end
    next_interrupt_request = next_interrupt_request & ~hw_clear;
    next_interrupt_request = next_interrupt_request | hw_set;
  end

  // ----------------------------------------------------------------
  // Interrupt output and main status bit
  // ----------------------------------------------------------------
  wire logic [5:0] req_gated;

  // Each request passes only with its own enable bit
  assign req_gated = interrupt_request & interrupt_enable;
  assign irq             = |req_gated;
  assign main_status_irq = irq;

  // ----------------------------------------------------------------
  // General control
  // ----------------------------------------------------------------
  wire logic wr_stop;
  wire logic wr_start;
  wire logic wr_flush;

  assign wr_stop  = wr_control & reg_wdata[reader_irq_pkg::BIT_TIMER_STOP];
  assign wr_start = wr_control & reg_wdata[reader_irq_pkg::BIT_TIMER_START];
  assign wr_flush = wr_control & reg_wdata[reader_irq_pkg::BIT_QUEUE_FLUSH];

  // Strobes last only the write cycle and are never stored
  assign timer_stop_strobe  = wr_stop;
  assign timer_start_strobe = wr_start;
  assign queue_flush_strobe = wr_flush;

  // Power bits are plain read/write; the cipher bit only falls by host
  always_comb begin
    next_standby            = standby;
    next_deep_sleep         = deep_sleep;
    next_card_cipher_active = card_cipher_active;
    if (wr_control) begin
      next_standby    = reg_wdata[reader_irq_pkg::BIT_STANDBY];
      next_deep_sleep = reg_wdata[reader_irq_pkg::BIT_DEEP_SLEEP];
      // Host may switch the cipher off but never on
      next_card_cipher_active = card_cipher_active &
        reg_wdata[reader_irq_pkg::BIT_CIPHER];
    end
    // Successful second authentication wins over a clearing write
    if (auth_step_two_ok) begin
      next_card_cipher_active = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [7:0] control_view;

  // Strobe bits and reserved bits are not stored and read as 0
  assign control_view = {2'b00, standby, deep_sleep,
                         card_cipher_active, 3'b000};

  // Unknown offsets answer 0; the host sees data one cycle after reg_rd
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      next_reg_rdata = reader_irq_pkg::RST_READ_DATA;
      if (hit_enable) begin
        next_reg_rdata = as_byte(interrupt_enable);
      end
      if (hit_request) begin
        next_reg_rdata = as_byte(interrupt_request);
      end
      if (hit_control) begin
        next_reg_rdata = control_view;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      interrupt_enable  <= reader_irq_pkg::RST_INTERRUPT_ENABLE[5:0];
      interrupt_request <= reader_irq_pkg::RST_INTERRUPT_REQUEST[5:0];
    end else begin
      interrupt_enable  <= next_interrupt_enable;
      interrupt_request <= next_interrupt_request;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      standby <= reader_irq_pkg::RST_GENERAL_CONTROL[
        reader_irq_pkg::BIT_STANDBY];
      deep_sleep <= reader_irq_pkg::RST_GENERAL_CONTROL[
        reader_irq_pkg::BIT_DEEP_SLEEP];
      card_cipher_active <= reader_irq_pkg::RST_GENERAL_CONTROL[
        reader_irq_pkg::BIT_CIPHER];
    end else begin
      standby            <= next_standby;
      deep_sleep         <= next_deep_sleep;
      card_cipher_active <= next_card_cipher_active;
    end
  end

  // ----------------------------------------------------------------
  // Edge history and read data
  // ----------------------------------------------------------------
  // Alert history resets high so a level already set at reset release
  // is not reported as a fresh event before it is seen to rise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alert_full_prev  <= 1'b1;
      alert_empty_prev <= 1'b1;
      cmd_was_busy     <= 1'b0;
      reg_rdata        <= reader_irq_pkg::RST_READ_DATA;
    end else begin
      alert_full_prev  <= fifo_near_full;
      alert_empty_prev <= fifo_near_empty;
      cmd_was_busy     <= ~cmd_is_idle;
      reg_rdata        <= next_reg_rdata;
    end
  end

endmodule : reader_irq_and_control

// ==== test/reader_irq_and_control_assertions.sv ====
module reader_irq_and_control_checker (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       auth_step_two_ok,
  input wire logic [6:0] queue_byte_count,
  input wire logic [5:0] alert_threshold,
  input wire logic       irq,
  input wire logic       main_status_irq,
  input wire logic       fifo_near_full,
  input wire logic       fifo_near_empty,
  input wire logic       standby,
  input wire logic       deep_sleep,
  input wire logic       card_cipher_active,
  input wire logic       timer_stop_strobe,
  input wire logic       timer_start_strobe,
  input wire logic       queue_flush_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  // Control writes decoded once, so strobes tie to the exact byte
  logic ctl_wr;
  assign ctl_wr = reg_wr &&
                  (reg_addr == reader_irq_pkg::OFS_GENERAL_CONTROL);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_status;
    irq == main_status_irq;
  endproperty
  a_status: assert property (p_status) else $error("status differs");
  property p_stop;
    timer_stop_strobe == (ctl_wr && reg_wdata[2]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop strobe wrong");
  property p_start;
    timer_start_strobe == (ctl_wr && reg_wdata[1]);
  endproperty
  a_start: assert property (p_start) else $error("start strobe");
  property p_flush;
    queue_flush_strobe == (ctl_wr && reg_wdata[0]);
  endproperty
  a_flush: assert property (p_flush) else $error("flush strobe");
  property p_full;
    fifo_near_full ==
      ((7'h40 - queue_byte_count) <= {1'b0, alert_threshold});
  endproperty
  a_full: assert property (p_full) else $error("near full wrong");
  property p_empty;
    fifo_near_empty == (queue_byte_count <= {1'b0, alert_threshold});
  endproperty
  a_empty: assert property (p_empty) else $error("near empty");
  // A host write must never turn the cipher on by itself
  property p_cipher;
    $past(rst_n) && $rose(card_cipher_active) |-> $past(auth_step_two_ok);
  endproperty
  a_cipher: assert property (p_cipher) else $error("cipher rose");
  property p_power;
    $past(rst_n) && ($changed(standby) || $changed(deep_sleep)) |->
      $past(ctl_wr) && standby == $past(reg_wdata[5]) &&
      deep_sleep == $past(reg_wdata[4]);
  endproperty
  a_power: assert property (p_power) else $error("power");
endmodule : reader_irq_and_control_checker

bind reader_irq_and_control reader_irq_and_control_checker chk_inst (.*);

// ==== test/host_model.sv ====
module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Host register cycles
  // ------------------------------------------------------------
  initial begin
    reg_addr  = 6'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // Whole byte with set/clear bit and mask; data inverted once released
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~v;
  endtask : wr
  // Read data lands one cycle after the strobe is raised
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
endmodule : host_model

// ==== test/test_reader_irq_and_control.sv ====
module test_reader_irq_and_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Stimulus, responses and bookkeeping
  // ------------------------------------------------------------
  logic       mclk, rst_n, reg_wr, reg_rd, receive_active, cmd_host_write;
  logic [7:0] evt, reg_wdata, reg_rdata, d;
  logic [5:0] reg_addr, cmd_code, alert_threshold;
  logic [6:0] queue_byte_count;
  logic [2:0] strb;
  logic       irq, main_status_irq, fifo_near_full, fifo_near_empty;
  logic       standby, deep_sleep, card_cipher_active;
  logic       timer_stop_strobe, timer_start_strobe, queue_flush_strobe;
  int         bad_count = 0, checks_done = 0, cycles = 0;
  // Rows: event pulse in the upper byte, request byte expected below
  logic [15:0] rows [7] = '{16'h0120, 16'h0210, 16'h0410, 16'h0810,
                            16'h1010, 16'h2008, 16'h4004};
  logic [5:0]  ofs [4] = '{6'h06, 6'h07, 6'h09, 6'h3f};
  logic [6:0]  qc [4] = '{7'h3c, 7'h3b, 7'h04, 7'h05};
  logic [1:0]  qa [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
  assign strb = {timer_stop_strobe, timer_start_strobe, queue_flush_strobe};
  reader_irq_and_control dut (
    .timer_zero       (evt[0]),
    .exchange_tx_done (evt[1]),
    .auth_tx_done     (evt[2]),
    .nv_prog_done     (evt[3]),
    .checksum_done    (evt[4]),
    .receive_done     (evt[5]),
    .unknown_cmd_start(evt[6]),
    .auth_step_two_ok (evt[7]),
    .*
  );
  host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic pulse(input logic [7:0] v);
    @(posedge mclk);
    evt <= v;
    @(posedge mclk);
    evt <= 8'h00;
  endtask : pulse
  task automatic wrc(input logic [5:0] a, input logic [7:0] w, e);
    host.wr(a, w);
    host.rd(a, d);
    chk("register", d, e);
  endtask : wrc
  // Every register, and an unmapped offset, reads zero after reset
  task automatic zero_reads();
    foreach (ofs[i]) begin
      host.rd(ofs[i], d);
      chk("reset", d, 8'h00);
    end
    chk("irq", 8'(irq), 8'h00);
  endtask : zero_reads
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // Run is about two hundred cycles; the ceiling only catches a hang
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0;
    evt = 8'h00;
    receive_active = 1'b0;
    cmd_host_write = 1'b0;
    cmd_code = 6'h00;
    queue_byte_count = 7'h20;
    alert_threshold = 6'h00;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    zero_reads();
    wrc(6'h06, 8'h85, 8'h05);
    wrc(6'h06, 8'h82, 8'h07);
    wrc(6'h06, 8'h04, 8'h03);
    wrc(6'h06, 8'h80, 8'h03);
    wrc(6'h06, 8'hff, 8'h3f);
    wrc(6'h06, 8'h3f, 8'h00);
    wrc(6'h07, 8'hbf, 8'h3f);
    chk("irq", 8'(irq), 8'h00);
    // One enable at a time must be enough to raise the pin
    for (int i = 0; i < 6; i++) begin
      host.wr(6'h06, 8'h80 | (8'h01 << i));
      #1;
      chk("irq", 8'(irq), 8'h01);
      host.wr(6'h06, 8'h01 << i);
    end
    wrc(6'h07, 8'h3f, 8'h00);
    wrc(6'h06, 8'hbf, 8'h3f);
    foreach (rows[i]) begin
      pulse(rows[i][15:8]);
      host.rd(6'h07, d);
      chk("request", d, rows[i][7:0]);
      chk("irq", 8'(irq), 8'h01);
      chk("status", 8'(main_status_irq), 8'h01);
      wrc(6'h07, 8'h3f, 8'h00);
      chk("irq", 8'(irq), 8'h00);
      chk("status", 8'(main_status_irq), 8'h00);
    end
    // Receiver end wins its cycle, ongoing reception then clears it
    @(posedge mclk);
    receive_active <= 1'b1;
    evt <= 8'h20;
    @(posedge mclk);
    evt <= 8'h00;
    #1;
    chk("irq", 8'(irq), 8'h01);
    @(posedge mclk);
    receive_active <= 1'b0;
    host.rd(6'h07, d);
    chk("request", d, 8'h00);
    // Return to idle flags completion unless the host wrote idle
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      cmd_code <= 6'h0c;
      @(posedge mclk);
      cmd_code <= 6'h00;
      cmd_host_write <= i[0];
      @(posedge mclk);
      cmd_host_write <= 1'b0;
      host.rd(6'h07, d);
      chk("request", d, (i == 0) ? 8'h04 : 8'h00);
      wrc(6'h07, 8'h04, 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      alert_threshold <= 6'h04;
      queue_byte_count <= qc[i];
      @(posedge mclk);
      #1;
      chk("alert", 8'({fifo_near_full, fifo_near_empty}),
          8'(qa[i]));
    end
    host.rd(6'h07, d);
    chk("request", d, 8'h03);
    wrc(6'h07, 8'h03, 8'h00);
    // Strobes last only the write cycle and never read back
    fork
      host.wr(6'h09, 8'h3f);
      begin
        @(posedge mclk);
        #1;
        chk("strobes", 8'(strb), 8'h07);
      end
    join
    host.rd(6'h09, d);
    chk("control", d, 8'h30);
    chk("power", 8'({standby, deep_sleep}), 8'h03);
    pulse(8'h80);
    host.rd(6'h09, d);
    chk("control", d, 8'h38);
    chk("cipher", 8'(card_cipher_active), 8'h01);
    wrc(6'h09, 8'h00, 8'h00);
    // Second reset in mid-run with enables still set; near-empty is
    // held high across release and must not latch a fresh flag
    @(posedge mclk);
    rst_n <= 1'b0;
    queue_byte_count <= 7'h04;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    zero_reads();
    complete_run();
  end
endmodule : test_reader_irq_and_control
